// File: ivm_pkg.sv
// package: constants and carrier types for the vector and move event block
package ivm_pkg;
  localparam int NUM_IRQ = 16;
  localparam int NUM_MOTOR = 3;
  localparam int PC_W = 16;
  localparam logic [7:0] OP_IRQ_ENABLE = 8'h19;
  localparam logic [7:0] OP_IRQ_DISABLE = 8'h1a;
  localparam logic [7:0] OP_DEFINE_VECTOR = 8'h25;
  localparam logic [7:0] OP_RETURN_HANDLER = 8'h26;
  localparam logic [7:0] OP_MOVE_POSITION = 8'h04;
  localparam logic [7:0] OP_USER_FIRST = 8'h40;
  localparam logic [7:0] OP_USER_LAST = 8'h47;
  localparam logic [7:0] OP_POS_REQUEST = 8'h8a;
  localparam logic [7:0] IRQ_GLOBAL = 8'hff;
  localparam logic [7:0] ST_OK = 8'h64;
  localparam logic [7:0] ST_EVENT = 8'h80;
  localparam logic [7:0] ST_BAD_CMD = 8'h02;
  localparam logic [7:0] ST_BAD_MODE = 8'h06;
  localparam logic [7:0] TYPE_ONCE = 8'h00;
  localparam logic [7:0] TYPE_EVERY = 8'h01;
  localparam logic [PC_W-1:0] PC_RESET = 16'h0000;
  localparam logic [31:0] WORD_RESET = 32'h0000_0000;

  typedef struct packed {
    logic [7:0] opcode;
    logic [7:0] cmdType;
    logic [7:0] bank;
    logic [31:0] value;
  } ivm_cmd_t;

  typedef struct packed {
    logic [7:0] status;
    logic [7:0] command;
    logic [31:0] value;
  } ivm_reply_t;

  typedef struct packed {
    logic [31:0] accu;
    logic [31:0] xReg;
    logic [7:0] flags;
    logic [PC_W-1:0] pc;
  } ivm_ctx_t;

  typedef enum logic [1:0] {
    NOTE_OFF = 2'b00,
    NOTE_ARMED = 2'b01,
    NOTE_WATCH = 2'b10
  } ivm_note_t;
endpackage

// File: ivm_core.sv
// module: handler vectors, context save and restore, move arrival replies
`timescale 1ns/100ps
module ivm_core (
  input wire logic clock, // system clock, 50 MHz
  input wire logic rst_n, // async reset, active low
  input wire logic clkEn, // freezes all state while low
  input wire logic cmdValid, // one-cycle command strobe
  input wire ivm_pkg::ivm_cmd_t cmdIn, // decoded command fields
  input wire logic cmdDirect, // high: command came from host frame
  input wire ivm_pkg::ivm_ctx_t ctxIn, // live interpreter context
  input wire logic [ivm_pkg::NUM_IRQ-1:0] irqEvent, // interrupt sources
  input wire logic [ivm_pkg::NUM_MOTOR-1:0] posReached, // per motor
  output logic replyValid, // one-cycle reply strobe
  output ivm_pkg::ivm_reply_t replyOut, // reply fields
  output logic ctxLoad, // one-cycle: take ctxOut into interpreter
  output ivm_pkg::ivm_ctx_t ctxOut, // context to load
  output logic inHandler, // handler routine running
  output logic irqGlobalOn // global interrupt switch state
);
  // ==========================================================
  // decode
  function automatic logic isUser(input logic [7:0] op);
    isUser = (op >= ivm_pkg::OP_USER_FIRST) && (op <= ivm_pkg::OP_USER_LAST);
  endfunction

  function automatic logic isOp(input ivm_pkg::ivm_cmd_t c,
                                input logic [7:0] op);
    isOp = (c.opcode == op);
  endfunction

  logic take;
  assign take = cmdValid && clkEn;

  // ==========================================================
  // vector table and enables
  logic [ivm_pkg::PC_W-1:0] vector_reg [ivm_pkg::NUM_IRQ];
  logic [ivm_pkg::NUM_IRQ-1:0] irqEnable_reg;
  logic [ivm_pkg::NUM_IRQ-1:0] irqPending_reg;
  logic globalOn_reg;
  logic inHandler_reg;
  ivm_pkg::ivm_ctx_t saved_reg;

  genvar gi;
  generate
    for (gi = 0; gi < ivm_pkg::NUM_IRQ; gi++) begin : gVec
      always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
          vector_reg[gi] <= ivm_pkg::PC_RESET;
        end else if (take && isOp(cmdIn, ivm_pkg::OP_DEFINE_VECTOR) &&
                     cmdIn.cmdType == 8'(gi)) begin
          // a later definition simply overwrites the earlier one
          vector_reg[gi] <= cmdIn.value[ivm_pkg::PC_W-1:0];
        end
      end
    end
  endgenerate

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      irqEnable_reg <= '0;
      globalOn_reg <= 1'b0;
    end else if (take) begin
      if (isOp(cmdIn, ivm_pkg::OP_IRQ_ENABLE)) begin
        if (cmdIn.cmdType == ivm_pkg::IRQ_GLOBAL) begin
          globalOn_reg <= 1'b1;
        end else if (cmdIn.cmdType < 8'(ivm_pkg::NUM_IRQ)) begin
          irqEnable_reg[cmdIn.cmdType[3:0]] <= 1'b1;
        end
      end else if (isOp(cmdIn, ivm_pkg::OP_IRQ_DISABLE)) begin
        if (cmdIn.cmdType == ivm_pkg::IRQ_GLOBAL) begin
          globalOn_reg <= 1'b0;
        end else if (cmdIn.cmdType < 8'(ivm_pkg::NUM_IRQ)) begin
          irqEnable_reg[cmdIn.cmdType[3:0]] <= 1'b0;
        end
      end
    end
  end

  // ==========================================================
  // interrupt entry and return
  logic [ivm_pkg::NUM_IRQ-1:0] ready;
  logic [3:0] pick;
  logic enter;
  logic leave;
  assign ready = irqPending_reg & irqEnable_reg;
  // entry waits for a command-free cycle so the saved pc is settled
  assign enter = clkEn && globalOn_reg && !inHandler_reg &&
                 (|ready) && !cmdValid;
  // a return from the host or outside a handler is refused
  assign leave = take && isOp(cmdIn, ivm_pkg::OP_RETURN_HANDLER) &&
                 !cmdDirect && inHandler_reg;

  always_comb begin
    pick = 4'h0;
    for (int i = ivm_pkg::NUM_IRQ - 1; i >= 0; i--) begin
      if (ready[i]) begin
        pick = 4'(i);
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      irqPending_reg <= '0;
    end else if (clkEn) begin
      // a new event wins over the clear of its own entry
      irqPending_reg <= (irqPending_reg &
                         ~(enter ? (16'h0001 << pick) : 16'h0000)) |
                        irqEvent;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      inHandler_reg <= 1'b0;
      saved_reg <= '0;
      ctxLoad <= 1'b0;
      ctxOut <= '0;
    end else if (clkEn) begin
      ctxLoad <= 1'b0;
      if (enter) begin
        saved_reg <= ctxIn;
        inHandler_reg <= 1'b1;
        ctxLoad <= 1'b1;
        ctxOut <= '{accu: ctxIn.accu, xReg: ctxIn.xReg,
                    flags: ctxIn.flags, pc: vector_reg[pick]};
      end else if (leave) begin
        inHandler_reg <= 1'b0;
        ctxLoad <= 1'b1;
        ctxOut <= saved_reg;
      end
    end
  end

  assign inHandler = inHandler_reg;
  assign irqGlobalOn = globalOn_reg;

  // ==========================================================
  // position reached notification
  ivm_pkg::ivm_note_t note_reg;
  logic noteEvery_reg;
  logic [ivm_pkg::NUM_MOTOR-1:0] mask_reg;
  logic [ivm_pkg::NUM_MOTOR-1:0] waiting_reg;
  logic posReq;
  logic posReqOk;
  logic moveCmd;
  logic arrive;
  assign posReq = take && isOp(cmdIn, ivm_pkg::OP_POS_REQUEST);
  assign posReqOk = posReq && cmdDirect &&
                    (cmdIn.cmdType == ivm_pkg::TYPE_ONCE ||
                     cmdIn.cmdType == ivm_pkg::TYPE_EVERY);
  assign moveCmd = take && isOp(cmdIn, ivm_pkg::OP_MOVE_POSITION);
  // all selected motors must arrive before the one event reply
  assign arrive = (note_reg == ivm_pkg::NOTE_WATCH) &&
                  ((waiting_reg & ~posReached) == '0);

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      note_reg <= ivm_pkg::NOTE_OFF;
      noteEvery_reg <= 1'b0;
      mask_reg <= '0;
      waiting_reg <= '0;
    end else if (clkEn) begin
      if (posReqOk) begin
        note_reg <= ivm_pkg::NOTE_ARMED;
        noteEvery_reg <= (cmdIn.cmdType == ivm_pkg::TYPE_EVERY);
        mask_reg <= cmdIn.value[ivm_pkg::NUM_MOTOR-1:0];
      end else begin
        case (note_reg)
          ivm_pkg::NOTE_ARMED: begin
            if (moveCmd) begin
              note_reg <= ivm_pkg::NOTE_WATCH;
              waiting_reg <= mask_reg;
            end
          end
          ivm_pkg::NOTE_WATCH: begin
            if (moveCmd) begin
              waiting_reg <= mask_reg;
            end else if (arrive) begin
              // type 0 drops back to off after one message
              note_reg <= noteEvery_reg ? ivm_pkg::NOTE_ARMED
                                        : ivm_pkg::NOTE_OFF;
            end
          end
          default: note_reg <= note_reg;
        endcase
      end
    end
  end

  // ==========================================================
  // replies: command reply first, a pending event reply the cycle after
  logic eventPend_reg;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      replyValid <= 1'b0;
      replyOut <= '0;
      eventPend_reg <= 1'b0;
    end else if (clkEn) begin
      replyValid <= 1'b0;
      if (arrive && !moveCmd && !posReqOk) begin
        eventPend_reg <= 1'b1;
      end
      if (take && cmdDirect) begin
        replyValid <= 1'b1;
        replyOut.command <= cmdIn.opcode;
        replyOut.value <= ivm_pkg::WORD_RESET;
        replyOut.status <= ivm_pkg::ST_OK;
        if (isUser(cmdIn.opcode)) begin
          replyOut.value <= cmdIn.value;
        end else if (posReq) begin
          replyOut.status <= posReqOk ? ivm_pkg::ST_OK
                                      : ivm_pkg::ST_BAD_CMD;
          replyOut.value <= {24'h000000, cmdIn.value[7:0]};
        end else if (isOp(cmdIn, ivm_pkg::OP_RETURN_HANDLER)) begin
          replyOut.status <= ivm_pkg::ST_BAD_MODE;
        end
      end else if (eventPend_reg) begin
        eventPend_reg <= arrive && !moveCmd && !posReqOk;
        replyValid <= 1'b1;
        replyOut.status <= ivm_pkg::ST_EVENT;
        replyOut.command <= ivm_pkg::OP_POS_REQUEST;
        replyOut.value <= {24'h000000,
                           {(8 - ivm_pkg::NUM_MOTOR){1'b0}}, mask_reg};
      end
    end
  end
endmodule

// File: ivm_host_model.sv
// partner: host side that issues command frames to the block
`timescale 1ns/100ps
module ivm_host_model (
  input wire logic clock, // system clock
  output logic cmdValid, // command strobe
  output ivm_pkg::ivm_cmd_t cmdIn, // command fields
  output logic cmdDirect // 1: host frame, 0: stored program
);
  initial begin
    cmdValid = 1'b0;
    cmdIn = '0;
    cmdDirect = 1'b1;
  end
  // one command per call; the gap cycle keeps strobes apart
  task automatic send(input logic [7:0] op, input logic [7:0] typ,
      input logic [31:0] val, input logic dir);
    @(posedge clock);
    #1;
    cmdValid = 1'b1;
    cmdIn = '{op, typ, 8'h00, val};
    cmdDirect = dir;
    @(posedge clock);
    #1;
    cmdValid = 1'b0;
    cmdIn = ~cmdIn; // released fields must not look valid
  endtask
endmodule

// File: ivm_chk.sv
// checker: port assertions for the vector and move event block
`timescale 1ns/100ps
module ivm_chk (
  input wire logic clock, // system clock
  input wire logic rst_n, // async reset, active low
  input wire logic clkEn, // run enable
  input wire logic cmdValid, // command strobe
  input wire ivm_pkg::ivm_cmd_t cmdIn, // command fields
  input wire logic cmdDirect, // host frame
  input wire ivm_pkg::ivm_ctx_t ctxIn, // live context
  input wire logic replyValid, // reply strobe
  input wire ivm_pkg::ivm_reply_t replyOut, // reply fields
  input wire logic ctxLoad, // context load strobe
  input wire ivm_pkg::ivm_ctx_t ctxOut, // context to load
  input wire logic inHandler, // handler running
  input wire logic irqGlobalOn // global switch
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  // ==========================================================
  // command takes, event reply format, handler entry and global switch
  sequence s_cmd(logic dir, logic [7:0] op);
    cmdValid && clkEn && cmdDirect == dir && cmdIn.opcode == op;
  endsequence
  a_direct_reply: assert property (
    cmdValid && clkEn && cmdDirect |=> replyValid) else $error("no reply");
  a_user_echo: assert property (
    cmdValid && clkEn && cmdDirect && cmdIn.opcode inside {[8'h40:8'h47]}
    |=> replyOut.status == ivm_pkg::ST_OK
    && replyOut.value == $past(cmdIn.value)) else $error("user reply");
  a_return_refused: assert property (
    s_cmd(1'b1, ivm_pkg::OP_RETURN_HANDLER) |=> !ctxLoad
    && replyOut.status == ivm_pkg::ST_BAD_MODE) else $error("direct ret");
  a_pos_program: assert property (
    s_cmd(1'b0, ivm_pkg::OP_POS_REQUEST) |=> !replyValid
    || replyOut.status == ivm_pkg::ST_EVENT) else $error("program 138");
  a_event_format: assert property (
    replyValid && replyOut.status == ivm_pkg::ST_EVENT
    |-> replyOut.command == ivm_pkg::OP_POS_REQUEST
    && replyOut.value[31:3] == '0) else $error("event format");
  a_entry_save: assert property (
    $rose(inHandler) |-> ctxLoad && ctxOut.accu == $past(ctxIn.accu)
    && ctxOut.xReg == $past(ctxIn.xReg)) else $error("entry context");
  a_return_restore: assert property (
    s_cmd(1'b0, ivm_pkg::OP_RETURN_HANDLER) ##0 inHandler
    |=> ctxLoad && !inHandler) else $error("return");
  a_global_off: assert property (
    !irqGlobalOn && !inHandler |=> !inHandler) else $error("entry while off");
  a_global_on: assert property (
    s_cmd(1'b0, ivm_pkg::OP_IRQ_ENABLE) ##0
    cmdIn.cmdType == ivm_pkg::IRQ_GLOBAL |=> irqGlobalOn)
    else $error("global enable");
endmodule
bind ivm_core ivm_chk i_ivm_chk (.clock, .rst_n, .clkEn, .cmdValid, .cmdIn,
  .cmdDirect, .ctxIn, .replyValid, .replyOut, .ctxLoad, .ctxOut,
  .inHandler, .irqGlobalOn);

// File: testbench.sv
// testbench: directed scenarios for the vector and move event block
`timescale 1ns/100ps
module testbench;
  logic clock, rst_n, clkEn, cmdValid, cmdDirect, replyValid, ctxLoad;
  logic inHandler, irqGlobalOn;
  ivm_pkg::ivm_cmd_t cmdIn;
  ivm_pkg::ivm_ctx_t ctxIn, ctxOut, ctxSave;
  ivm_pkg::ivm_reply_t replyOut;
  logic [15:0] irqEvent;
  logic [2:0] posReached;
  int n_errors = 0;
  int n_compared = 0;
  ivm_core i_ivm_core (.clock, .rst_n, .clkEn, .cmdValid, .cmdIn,
    .cmdDirect, .ctxIn, .irqEvent, .posReached, .replyValid, .replyOut,
    .ctxLoad, .ctxOut, .inHandler, .irqGlobalOn);
  ivm_host_model i_host (.clock, .cmdValid, .cmdIn, .cmdDirect);
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  // ==========================================================
  // shared tasks
  task automatic check(input string what, input logic [87:0] seen, exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic end_of_test();
    $display("errors %0d compared %0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0) begin
      $display("Result: passed");
    end
    else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // sel 0 watches replyValid, sel 1 watches ctxLoad
  task automatic wait_for(input bit sel, input int limit);
    for (int k = 0; k < limit; k++) begin
      if ((sel ? ctxLoad : replyValid) === 1'b1) return;
      @(posedge clock);
      #1;
    end
    check("wait", 1'b0, 1'b1);
    end_of_test();
  endtask
  // sel 0 expects no reply, sel 1 expects no handler entry
  task automatic quiet(input bit sel, input int n);
    repeat (n) begin
      @(posedge clock);
      #1;
      check("quiet", sel ? inHandler : replyValid, 1'b0);
    end
  endtask
  // ==========================================================
  // scenarios
  task automatic t_user();
    for (int op = 64; op < 72; op++) begin
      i_host.send(8'(op), 8'h00, 32'h5a00_0000 | op, 1'b1);
      check("user", {replyValid, replyOut.status, replyOut.value},
        {1'b1, ivm_pkg::ST_OK, 32'h5a00_0000 | op});
    end
  endtask
  task automatic t_refused();
    i_host.send(ivm_pkg::OP_RETURN_HANDLER, 8'hff, 32'h0, 1'b1);
    check("direct return", replyOut.status, ivm_pkg::ST_BAD_MODE);
    i_host.send(ivm_pkg::OP_POS_REQUEST, 8'h02, 32'h5, 1'b1);
    check("bad type", replyOut.status, ivm_pkg::ST_BAD_CMD);
    i_host.send(ivm_pkg::OP_DEFINE_VECTOR, 8'h05, 32'h0040, 1'b1);
    check("vector reply", replyOut.status, ivm_pkg::ST_OK);
    // a return outside any handler must not touch the context
    i_host.send(ivm_pkg::OP_RETURN_HANDLER, 8'h00, 32'h0, 1'b0);
    check("stray return", ctxLoad, 1'b0);
    i_host.send(ivm_pkg::OP_POS_REQUEST, 8'h01, 32'h5, 1'b0);
    quiet(1'b0, 4);
  endtask
  task automatic t_irq();
    i_host.send(ivm_pkg::OP_DEFINE_VECTOR, 8'h03, 32'h0032, 1'b0);
    i_host.send(ivm_pkg::OP_DEFINE_VECTOR, 8'h03, 32'h0077, 1'b0);
    i_host.send(ivm_pkg::OP_IRQ_ENABLE, 8'h03, 32'h0, 1'b0);
    i_host.send(ivm_pkg::OP_IRQ_ENABLE, ivm_pkg::IRQ_GLOBAL, 32'h0, 1'b0);
    check("global on", irqGlobalOn, 1'b1);
    ctxIn = {32'h1111_2222, 32'h3333_4444, 8'h5a, 16'h0123};
    ctxSave = ctxIn;
    irqEvent = 16'h0008;
    @(posedge clock);
    #1;
    irqEvent = '0;
    wait_for(1'b1, 10);
    check("entry ctx", ctxOut, {ctxSave[87:16], 16'h0077});
    ctxIn = ~ctxSave;
    i_host.send(ivm_pkg::OP_RETURN_HANDLER, 8'h00, 32'h0, 1'b0);
    wait_for(1'b1, 4);
    check("restored ctx", ctxOut, ctxSave);
    check("left handler", inHandler, 1'b0);
    i_host.send(ivm_pkg::OP_IRQ_DISABLE, 8'h03, 32'h0, 1'b0);
    irqEvent = 16'h0008;
    @(posedge clock);
    #1;
    irqEvent = '0;
    quiet(1'b1, 4);
    // pending stays set, so re-enabling it tests only the global switch
    i_host.send(ivm_pkg::OP_IRQ_DISABLE, ivm_pkg::IRQ_GLOBAL, 32'h0, 1'b0);
    i_host.send(ivm_pkg::OP_IRQ_ENABLE, 8'h03, 32'h0, 1'b0);
    quiet(1'b1, 8);
  endtask
  task automatic t_pos(input logic [7:0] typ);
    i_host.send(ivm_pkg::OP_POS_REQUEST, typ, 32'h5, 1'b1);
    check("request", replyOut.status, ivm_pkg::ST_OK);
    for (int m = 0; m < 2; m++) begin
      posReached = 3'b000;
      i_host.send(ivm_pkg::OP_MOVE_POSITION, 8'h00, 32'h0, 1'b0);
      posReached = 3'b001;
      quiet(1'b0, 3);
      posReached = 3'b101;
      if (m == 0 || typ == ivm_pkg::TYPE_EVERY) begin
        wait_for(1'b0, 10);
        check("event", replyOut, {8'h80, 8'h8a, 32'h5});
      end
      else begin
        quiet(1'b0, 10);
      end
    end
  endtask
  initial begin
    rst_n = 1'b0;
    clkEn = 1'b1;
    ctxIn = '0;
    irqEvent = '0;
    posReached = '0;
    repeat (12) @(posedge clock);
    #1;
    rst_n = 1'b1;
    t_user();
    t_refused();
    t_irq();
    t_pos(ivm_pkg::TYPE_ONCE);
    t_pos(ivm_pkg::TYPE_EVERY);
    end_of_test();
  end
endmodule
